// ### src/integer_multiply_unit.sv
// Integer multiply datapath with its working registers on an APB slave.
//
// Design decisions made here: the APB interface to the registers and the address map.
`timescale 1ns/10ps

module integer_multiply_unit
	import mul_unit_pkg::*;
#(
	parameter int ADDR_W = 8 // APB address width.
) (
	input  wire logic              clock_i,   // Core clock, 40 MHz.
	input  wire logic              rst_n_i,   // Synchronous reset, low.
	input  wire logic              psel_i,    // APB select.
	input  wire logic              penable_i, // APB access phase.
	input  wire logic              pwrite_i,  // APB direction, high writes.
	input  wire logic [ADDR_W-1:0] paddr_i,   // APB byte address.
	input  wire logic [31:0]       pwdata_i,  // APB write data.
	output logic      [31:0]       prdata_o,  // APB read data.
	output logic                   pready_o,  // APB ready.
	output logic                   pslverr_o  // APB error, unmapped.
);

	// Bus state.
	logic        pready_q;   // High in the single access cycle.
	logic [31:0] prdata_q;   // Read data captured at the setup edge.
	logic        pslverr_q;  // Error captured at the setup edge.

	// Architectural state.
	logic [15:0] default_work_reg_q [16];       // Working register array.
	logic [15:0] core_control_reg_q; // Mode bits of the core.
	logic [15:0] mem_data_q;        // Stands in for the data memory word.
	logic [39:0] accumulator_a_q;   // First accumulator.
	logic [39:0] accumulator_b_q;   // Second accumulator.
	logic        illegal_q;         // Sticky unknown opcode flag.
	logic        byte_mode_q;       // Last file product was byte mode.
	logic [12:0] file_addr_q;       // Last file register address.
	logic [15:0] eaddr_q;           // Last source address; source register value in direct mode.

	// Bus decode.
	logic              setup;      // Setup cycle of a transfer.
	logic              access;     // Edge at which a transfer completes.
	logic              wr;         // Completing write.
	logic              hit;        // Address maps to a register.
	logic              default_work_reg_hit;   // Address falls in the W window.
	logic [3:0]        default_work_reg_idx;   // Index inside the W window.
	logic [ADDR_W-1:0] addr_al;    // Word-aligned address.
	logic [31:0]       rd_mux;     // Data of the addressed register.

	// Instruction decode.
	logic        exec;       // Instruction issued this edge.
	logic [23:0] op;         // Instruction word.
	form_t       form;       // Decoded form.
	logic [3:0]  base_idx;   // base_operand_reg field.
	logic [3:0]  dest_idx;   // Destination field.
	logic [3:0]  src_idx;    // source_operand_reg field.
	logic [2:0]  src_mode;   // Source addressing mode.
	logic [4:0]  lit;        // short_literal.
	logic        acc_sel;    // High selects accumulator_b.
	logic        frac_mode;  // Fraction arithmetic selected.

	// Operand and product paths.
	logic [15:0] base_val;   // Base operand.
	logic [15:0] src_reg;    // Contents of the source register.
	logic [15:0] src_val;    // Source operand after addressing.
	logic [15:0] ptr_new;    // Updated source pointer.
	logic        ptr_we;     // Source pointer is written back.
	logic [15:0] ea;         // Address of an indirect source.
	logic [31:0] base_ext;   // Base, sign-extended to 32 bits.
	logic [31:0] prod_file;  // Unsigned word file product.
	logic [15:0] prod_byte;  // Unsigned byte file product.
	logic [31:0] prod_ss;    // Signed by signed product.
	logic [31:0] prod_lit;   // Signed by literal product.
	logic [32:0] prod_acc;   // Accumulator product before extension.
	logic [39:0] acc_val;    // Value loaded into an accumulator.

	// Result write ports into the working registers.
	logic        lo_we;      // Low result word is written.
	logic        hi_we;      // High result word is written.
	logic [3:0]  lo_idx;     // Register of the low word.
	logic [3:0]  hi_idx;     // Register of the high word.
	logic [15:0] lo_val;     // Low result word.
	logic [15:0] hi_val;     // High result word.

	// Transfer phases; a request completes one cycle after its setup.
	assign setup    = psel_i & ~penable_i;
	assign access   = psel_i & penable_i & pready_q;
	assign wr       = access & pwrite_i;
	assign addr_al  = {paddr_i[ADDR_W-1:2], 2'b00};
	assign default_work_reg_hit = (addr_al >= ADDR_W'(OFS_DEFAULT_WORK_REG_BASE))
		&& (addr_al <= ADDR_W'(OFS_DEFAULT_WORK_REG_LAST));
	assign default_work_reg_idx = paddr_i[5:2];
	assign hit      = (paddr_i[1:0] == 2'b00) && (default_work_reg_hit
		|| addr_al == ADDR_W'(OFS_INSTR)
		|| addr_al == ADDR_W'(OFS_MEM_DATA)
		|| addr_al == ADDR_W'(OFS_CORE_CTRL)
		|| addr_al == ADDR_W'(OFS_STATUS)
		|| addr_al == ADDR_W'(OFS_ACCUMULATOR_A_LO)
		|| addr_al == ADDR_W'(OFS_ACCUMULATOR_A_HI)
		|| addr_al == ADDR_W'(OFS_ACCUMULATOR_B_LO)
		|| addr_al == ADDR_W'(OFS_ACCUMULATOR_B_HI)
		|| addr_al == ADDR_W'(OFS_EADDR));

	// Writing the instruction register executes it at that very edge.
	assign exec = wr && hit && (addr_al == ADDR_W'(OFS_INSTR));
	assign op   = pwdata_i[23:0];

	// Field extraction shared by all forms.
	assign base_idx  = op[14:11];
	assign dest_idx  = op[10:7];
	assign src_mode  = op[6:4];
	assign src_idx   = op[3:0];
	assign lit       = op[4:0];
	assign acc_sel   = op[7];
	assign frac_mode = ~core_control_reg_q[CTRL_INT_FRAC];

	// Form decode; anything outside the four forms is refused.
	always_comb begin
		form = FORM_NONE;
		if (op[23:16] == OPC_FILE && op[15] == 1'b0 && op[13] == 1'b0) begin
			form = FORM_FILE;
		end else if (op[23:16] == OPC_PAIR && op[15]) begin
			// Modes 110 and 111 are not source modes of this group.
			if (src_mode <= MODE_PRED) begin
				if (op[10:8] == DEST_ACC) begin
					form = FORM_ACC;
				end else begin
					form = FORM_PAIR;
				end
			end
		end else if (op[23:16] == OPC_PAIR && op[6:5] == LIT_MARK) begin
			// The accumulator literal variant is not built here.
			if (op[10:8] != DEST_ACC) begin
				form = FORM_LIT;
			end
		end
	end

	// Source operand addressing: the pointer moves by one word.
	always_comb begin
		src_reg = default_work_reg_q[src_idx];
		ptr_new = src_reg;
		ptr_we  = 1'b0;
		ea      = src_reg;
		case (src_mode)
			MODE_POSTI: begin
				ptr_new = src_reg + PTR_STEP;
				ptr_we  = 1'b1;
			end
			MODE_POSTD: begin
				ptr_new = src_reg - PTR_STEP;
				ptr_we  = 1'b1;
			end
			MODE_PREI: begin
				ptr_new = src_reg + PTR_STEP;
				ptr_we  = 1'b1;
				ea      = ptr_new;
			end
			MODE_PRED: begin
				ptr_new = src_reg - PTR_STEP;
				ptr_we  = 1'b1;
				ea      = ptr_new;
			end
			default: begin
				ptr_we = 1'b0;
			end
		endcase
		// The memory word is supplied for the address shown in eaddr.
		src_val = (src_mode == MODE_DIRECT) ? src_reg : mem_data_q;
	end

	// Products; each uses plain register contents, so no mode bit enters.
	assign base_val  = default_work_reg_q[base_idx];
	assign base_ext  = {{16{base_val[15]}}, base_val};
	assign prod_file = {16'h0000, default_work_reg_q[IDX_DEFAULT]}
		* {16'h0000, mem_data_q};
	assign prod_byte = {8'h00, default_work_reg_q[IDX_DEFAULT][7:0]}
		* {8'h00, mem_data_q[7:0]};
	assign prod_ss   = base_ext * {{16{src_val[15]}}, src_val};
	assign prod_lit  = base_ext * {27'h0000000, lit};

	// Fraction mode doubles the product so the binary point stays put.
	assign prod_acc = frac_mode ? {prod_ss, 1'b0}
		: {prod_ss[31], prod_ss};
	assign acc_val  = {{7{prod_acc[32]}}, prod_acc};

	// Result routing to the working registers.
	always_comb begin
		lo_we  = 1'b0;
		hi_we  = 1'b0;
		lo_idx = dest_idx;
		hi_idx = dest_idx + 4'h1;
		lo_val = prod_ss[15:0];
		hi_val = prod_ss[31:16];
		case (form)
			FORM_FILE: begin
				lo_we  = exec;
				hi_we  = exec & ~op[14];
				lo_idx = IDX_FILE_LO;
				hi_idx = IDX_FILE_HI;
				// Byte mode writes the whole 16-bit product to W2 only.
				lo_val = op[14] ? prod_byte : prod_file[15:0];
				hi_val = prod_file[31:16];
			end
			FORM_PAIR: begin
				// An odd or out-of-range destination is the caller's fault.
				lo_we = exec;
				hi_we = exec;
			end
			FORM_LIT: begin
				lo_we  = exec;
				hi_we  = exec;
				lo_val = prod_lit[15:0];
				hi_val = prod_lit[31:16];
			end
			default: begin
				lo_we = 1'b0;
			end
		endcase
	end

	// One always_ff per working register; the result outranks the pointer.
	generate
		for (genvar i = 0; i < 16; i++) begin : g_default_work_reg
			always_ff @(posedge clock_i) begin
				if (!rst_n_i) begin
					default_work_reg_q[i] <= RST_DEFAULT_WORK_REG;
				end else if (wr && hit && default_work_reg_hit
					&& default_work_reg_idx == 4'(i)) begin
					// A misaligned write is refused and leaves W untouched.
					default_work_reg_q[i] <= pwdata_i[15:0];
				end else if (lo_we && lo_idx == 4'(i)) begin
					default_work_reg_q[i] <= lo_val;
				end else if (hi_we && hi_idx == 4'(i)) begin
					default_work_reg_q[i] <= hi_val;
				end else if (exec && ptr_we && src_idx == 4'(i)
					&& (form == FORM_PAIR || form == FORM_ACC)) begin
					default_work_reg_q[i] <= ptr_new;
				end
			end
		end
	endgenerate

	// Accumulators: loaded by the accumulator form or written by software.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			accumulator_a_q <= RST_ACC;
			accumulator_b_q <= RST_ACC;
		end else if (exec && form == FORM_ACC) begin
			// Sign mode bits never reach this path.
			if (acc_sel) begin
				accumulator_b_q <= acc_val;
			end else begin
				accumulator_a_q <= acc_val;
			end
		end else if (wr && hit) begin
			if (addr_al == ADDR_W'(OFS_ACCUMULATOR_A_LO)) begin
				accumulator_a_q[31:0] <= pwdata_i;
			end else if (addr_al == ADDR_W'(OFS_ACCUMULATOR_A_HI)) begin
				accumulator_a_q[39:32] <= pwdata_i[7:0];
			end else if (addr_al == ADDR_W'(OFS_ACCUMULATOR_B_LO)) begin
				accumulator_b_q[31:0] <= pwdata_i;
			end else if (addr_al == ADDR_W'(OFS_ACCUMULATOR_B_HI)) begin
				accumulator_b_q[39:32] <= pwdata_i[7:0];
			end
		end
	end

	// Mode register and memory operand word, both plain software storage.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			core_control_reg_q <= RST_CORE_CTRL;
			mem_data_q         <= 16'h0000;
		end else if (wr && hit) begin
			if (addr_al == ADDR_W'(OFS_CORE_CTRL)) begin
				core_control_reg_q <= pwdata_i[15:0];
			end else if (addr_al == ADDR_W'(OFS_MEM_DATA)) begin
				mem_data_q <= pwdata_i[15:0];
			end
		end
	end

	// Decode status; a refused opcode sets the flag even while cleared.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			illegal_q <= 1'b0;
		end else if (exec && form == FORM_NONE) begin
			illegal_q <= 1'b1;
		end else if (wr && hit && addr_al == ADDR_W'(OFS_STATUS)
			&& pwdata_i[STAT_ILLEGAL]) begin
			illegal_q <= 1'b0;
		end
	end

	// Trace of the last file address, byte mode and source address.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			byte_mode_q <= 1'b0;
			file_addr_q <= 13'h0000;
			eaddr_q     <= 16'h0000;
		end else if (exec && form == FORM_FILE) begin
			byte_mode_q <= op[14];
			file_addr_q <= op[12:0];
		end else if (exec && (form == FORM_PAIR || form == FORM_ACC)) begin
			eaddr_q <= ea;
		end
	end

	// Read multiplexer, decoded by address.
	always_comb begin
		rd_mux = 32'h00000000;
		if (default_work_reg_hit) begin
			rd_mux = {16'h0000, default_work_reg_q[default_work_reg_idx]};
		end else if (addr_al == ADDR_W'(OFS_MEM_DATA)) begin
			rd_mux = {16'h0000, mem_data_q};
		end else if (addr_al == ADDR_W'(OFS_CORE_CTRL)) begin
			rd_mux = {16'h0000, core_control_reg_q};
		end else if (addr_al == ADDR_W'(OFS_STATUS)) begin
			rd_mux[STAT_ILLEGAL] = illegal_q;
			rd_mux[STAT_BYTE]    = byte_mode_q;
			rd_mux[STAT_FADDR_LO +: 13] = file_addr_q;
		end else if (addr_al == ADDR_W'(OFS_ACCUMULATOR_A_LO)) begin
			rd_mux = accumulator_a_q[31:0];
		end else if (addr_al == ADDR_W'(OFS_ACCUMULATOR_A_HI)) begin
			rd_mux = {24'h000000, accumulator_a_q[39:32]};
		end else if (addr_al == ADDR_W'(OFS_ACCUMULATOR_B_LO)) begin
			rd_mux = accumulator_b_q[31:0];
		end else if (addr_al == ADDR_W'(OFS_ACCUMULATOR_B_HI)) begin
			rd_mux = {24'h000000, accumulator_b_q[39:32]};
		end else if (addr_al == ADDR_W'(OFS_EADDR)) begin
			rd_mux = {16'h0000, eaddr_q};
		end
	end

	// Slave answer: ready and data are registered at the setup edge.
	// This costs one wait-free access cycle but keeps every output a flop.
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~hit;
			if (setup) begin
				prdata_q <= (hit && !pwrite_i) ? rd_mux : 32'h00000000;
			end
		end
	end

	assign pready_o  = pready_q;
	assign prdata_o  = prdata_q;
	assign pslverr_o = pslverr_q;

endmodule

// ### include/mul_unit_pkg.sv
// Constants, register map and decode fields of the integer multiply unit.
package mul_unit_pkg;

	// Register byte offsets on the APB bus.
	localparam logic [7:0] OFS_INSTR     = 8'h00; // Instruction issue.
	localparam logic [7:0] OFS_MEM_DATA  = 8'h04; // Memory operand word.
	localparam logic [7:0] OFS_CORE_CTRL = 8'h08; // core_control_reg.
	localparam logic [7:0] OFS_STATUS    = 8'h0C; // Decode status.
	localparam logic [7:0] OFS_ACCUMULATOR_A_LO   = 8'h10; // accumulator_a bits 31:0.
	localparam logic [7:0] OFS_ACCUMULATOR_A_HI   = 8'h14; // accumulator_a bits 39:32.
	localparam logic [7:0] OFS_ACCUMULATOR_B_LO   = 8'h18; // accumulator_b bits 31:0.
	localparam logic [7:0] OFS_ACCUMULATOR_B_HI   = 8'h1C; // accumulator_b bits 39:32.
	localparam logic [7:0] OFS_EADDR     = 8'h20; // Last source address.
	localparam logic [7:0] OFS_DEFAULT_WORK_REG_BASE = 8'h40; // W0, then one word each.
	localparam logic [7:0] OFS_DEFAULT_WORK_REG_LAST = 8'h7C; // W15.

	// Reset values.
	localparam logic [15:0] RST_CORE_CTRL = 16'h0000; // Fractional mode.
	localparam logic [15:0] RST_DEFAULT_WORK_REG      = 16'h0000;
	localparam logic [39:0] RST_ACC       = 40'h00_0000_0000;

	// Field positions in core_control_reg.
	localparam int CTRL_INT_FRAC = 0; // 1 selects integer, 0 fraction.
	localparam int CTRL_SIGN_LO  = 12; // multiplier_sign_mode low bit.
	localparam int CTRL_SIGN_HI  = 13; // multiplier_sign_mode high bit.

	// Field positions in the status register.
	localparam int STAT_ILLEGAL  = 0;  // Sticky, write one to clear.
	localparam int STAT_BYTE     = 1;  // Last file product was byte mode.
	localparam int STAT_FADDR_LO = 16; // Last 13-bit file address.

	// Opcode prefixes in bits 23:16 of the instruction word.
	localparam logic [7:0] OPC_FILE = 8'hBC; // unsigned_file_product.
	localparam logic [7:0] OPC_PAIR = 8'hB9; // Register pair group.

	// Fixed field values inside the instruction word.
	localparam logic [2:0] DEST_ACC    = 3'b111; // Accumulator target.
	localparam logic [1:0] LIT_MARK    = 2'b11;  // short_literal form.
	localparam logic [2:0] MODE_DIRECT = 3'b000;
	localparam logic [2:0] MODE_IND    = 3'b001;
	localparam logic [2:0] MODE_POSTI  = 3'b010;
	localparam logic [2:0] MODE_POSTD  = 3'b011;
	localparam logic [2:0] MODE_PREI   = 3'b100;
	localparam logic [2:0] MODE_PRED   = 3'b101;
	localparam logic [15:0] PTR_STEP   = 16'h0002; // Word step of a pointer.

	// Implicit operand and result registers of the file product.
	localparam logic [3:0] IDX_DEFAULT = 4'h0; // default_work_reg.
	localparam logic [3:0] IDX_FILE_LO = 4'h2;
	localparam logic [3:0] IDX_FILE_HI = 4'h3;

	// Decoded instruction forms, one-hot.
	typedef enum logic [4:0] {
		FORM_NONE    = 5'b00001,
		FORM_FILE    = 5'b00010,
		FORM_PAIR    = 5'b00100,
		FORM_ACC     = 5'b01000,
		FORM_LIT     = 5'b10000
	} form_t;

endpackage

// ### dv/integer_multiply_unit_properties.sv
// Port-level assertions for the integer multiply unit.
`timescale 1ns/10ps
module integer_multiply_unit_properties
	import mul_unit_pkg::*;
#(
	parameter int ADDR_W = 8 // APB address width.
) (
	input wire logic              clock_i,   // Core clock.
	input wire logic              rst_n_i,   // Synchronous reset, low.
	input wire logic              psel_i,    // APB select.
	input wire logic              penable_i, // APB access phase.
	input wire logic              pwrite_i,  // APB direction.
	input wire logic [ADDR_W-1:0] paddr_i,   // APB byte address.
	input wire logic [31:0]       pwdata_i,  // APB write data.
	input wire logic [31:0]       prdata_o,  // APB read data.
	input wire logic              pready_o,  // APB ready.
	input wire logic              pslverr_o  // APB error.
);
	// A setup cycle is select without the access phase.
	wire logic setup = psel_i && !penable_i;
	wire logic rd_setup = setup && !pwrite_i; // Setup of a read.
	// Aligned word inside the working register window.
	wire logic default_work_reg_hit = paddr_i >= OFS_DEFAULT_WORK_REG_BASE &&
		paddr_i <= OFS_DEFAULT_WORK_REG_LAST && paddr_i[1:0] == 2'b00;
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	property p_ready_after_setup; setup |=> pready_o; endproperty
	a_ready_after_setup: assert property (p_ready_after_setup)
		else $error("Ready missing after setup.");
	property p_ready_pulse; pready_o |=> !pready_o; endproperty
	a_ready_pulse: assert property (p_ready_pulse)
		else $error("Ready held longer than one cycle.");
	property p_ready_cause;
		pready_o |-> $past(psel_i) && !$past(penable_i);
	endproperty
	a_ready_cause: assert property (p_ready_cause)
		else $error("Ready without a setup cycle.");
	property p_err_unaligned;
		setup && paddr_i[1:0] != 2'b00 |=> pslverr_o && pready_o;
	endproperty
	a_err_unaligned: assert property (p_err_unaligned)
		else $error("Misaligned access not refused.");
	property p_err_data; pslverr_o |-> pready_o && prdata_o == 32'h0;
	endproperty
	a_err_data: assert property (p_err_data)
		else $error("Error answer with data or without ready.");
	property p_default_work_reg_word; rd_setup && default_work_reg_hit |=> !pslverr_o &&
		prdata_o[31:16] == 16'h0000; endproperty
	a_default_work_reg_word: assert property (p_default_work_reg_word)
		else $error("Working register read not a clean word.");
	property p_acc_hi; rd_setup && (paddr_i == OFS_ACCUMULATOR_A_HI ||
		paddr_i == OFS_ACCUMULATOR_B_HI) |=> prdata_o[31:8] == 24'h0; endproperty
	a_acc_hi: assert property (p_acc_hi)
		else $error("Accumulator upper part wider than eight bits.");
	property p_instr_wo; rd_setup && paddr_i == OFS_INSTR |=>
		prdata_o == 32'h0 && !pslverr_o; endproperty
	a_instr_wo: assert property (p_instr_wo)
		else $error("Instruction register read not zero.");
	property p_data_holds; !setup |=> $stable(prdata_o); endproperty
	a_data_holds: assert property (p_data_holds)
		else $error("Read data changed outside a setup edge.");
	// Main scenarios seen at the ports.
	c_exec: cover property (setup && pwrite_i && paddr_i == OFS_INSTR);
	c_err: cover property (pslverr_o);
	c_acc: cover property (rd_setup && paddr_i == OFS_ACCUMULATOR_B_LO);
endmodule

bind integer_multiply_unit integer_multiply_unit_properties #(
	.ADDR_W(ADDR_W)) u_props (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
	.paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
	.pready_o(pready_o), .pslverr_o(pslverr_o));

// ### dv/testbench.sv
// Self-checking testbench for the integer multiply unit.
`timescale 1ns/10ps
module testbench;
	import mul_unit_pkg::*;
	logic        clock_i = 1'b0;   // Core clock, 25 ns.
	logic        rst_n_i = 1'b0;   // Reset, active low.
	logic        psel_i = 1'b0;    // APB select.
	logic        penable_i = 1'b0; // APB access phase.
	logic        pwrite_i = 1'b0;  // APB direction.
	logic [7:0]  paddr_i = 8'h00;  // APB address.
	logic [31:0] pwdata_i = 32'h0; // APB write data.
	logic [31:0] prdata_o;         // APB read data.
	logic        pready_o;         // APB ready.
	logic        pslverr_o;        // APB error.
	int          failures = 0;     // Mismatches seen.
	int          cmp_count = 0;    // Comparisons made.
	logic [31:0] rd;               // Data of the last read.
	logic        err;              // Error flag of the last transfer.
	logic [15:0] ptr;              // Expected pointer after a mode.
	logic [31:0] prod;             // Expected pair product.

	always #12.5 clock_i = ~clock_i;

	integer_multiply_unit #(.ADDR_W(8)) DUT (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));

	// Counts every comparison; case inequality keeps unknowns failing.
	task automatic check(input logic [39:0] seen, input logic [39:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Prints the verdict and ends the run.
	task automatic test_done();
		if (failures == 0 && cmp_count > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	// One APB transfer; the wait for ready is bounded by the watchdog.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clock_i);
		psel_i <= 1'b1;
		penable_i <= 1'b0;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clock_i);
		penable_i <= 1'b1;
		do @(posedge clock_i); while (pready_o !== 1'b1);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	// Byte address of a working register.
	function automatic logic [7:0] wa(input logic [3:0] i);
		return OFS_DEFAULT_WORK_REG_BASE + {2'b00, i, 2'b00};
	endfunction

	task automatic expect_rd(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		check({8'h00, rd}, {8'h00, e});
	endtask

	task automatic setw(input logic [3:0] i, input logic [15:0] v);
		apb(1'b1, wa(i), {16'h0000, v});
	endtask

	task automatic exec(input logic [23:0] op);
		apb(1'b1, OFS_INSTR, {8'h00, op});
	endtask

	// Main sequence of scenarios.
	initial begin
		repeat (5) @(posedge clock_i);
		rst_n_i <= 1'b1;
		expect_rd(OFS_CORE_CTRL, 32'h0);
		expect_rd(OFS_INSTR, 32'h0);
		// Byte file product in integer mode; W3 must stay as it was.
		apb(1'b1, OFS_CORE_CTRL, 32'h1);
		setw(4'h0, 16'h9823);
		setw(4'h3, 16'hFFFF);
		apb(1'b1, OFS_MEM_DATA, 32'h2690);
		exec(24'hBC4800);
		expect_rd(wa(4'h2), 32'h13B0);
		expect_rd(wa(4'h3), 32'hFFFF);
		expect_rd(OFS_STATUS, 32'h0800_0002);
		// Word product at the top file address, fraction mode.
		apb(1'b1, OFS_CORE_CTRL, 32'h0);
		setw(4'h0, 16'hF001);
		apb(1'b1, OFS_MEM_DATA, 32'h3287);
		exec(24'hBC1FFF);
		expect_rd(wa(4'h2), 32'hC287);
		expect_rd(wa(4'h3), 32'h2F5E);
		expect_rd(OFS_STATUS, 32'h1FFF_0000);
		expect_rd(wa(4'h0), 32'hF001);
		// Signed pair product into W12:W13, modes set that must not matter.
		apb(1'b1, OFS_CORE_CTRL, 32'h3001);
		setw(4'h0, 16'h9823);
		setw(4'h1, 16'h67DC);
		exec(24'hB98601);
		expect_rd(wa(4'hC), 32'hD314);
		expect_rd(wa(4'hD), 32'hD5DC);
		// Every source mode through pointer W4.
		setw(4'h2, 16'h0045);
		apb(1'b1, OFS_MEM_DATA, 32'h0098);
		for (int m = 0; m < 6; m++) begin
			setw(4'h4, 16'h27FE);
			exec({16'hB990, 1'b0, 3'(m), 4'h4});
			prod = 32'h45 * ((m == 0) ? 32'h27FE : 32'h98);
			ptr = 16'h27FE;
			if (m == 2 || m == 4) ptr = ptr + PTR_STEP;
			if (m == 3 || m == 5) ptr = ptr - PTR_STEP;
			expect_rd(wa(4'h0), {16'h0, prod[15:0]});
			expect_rd(wa(4'h1), {16'h0, prod[31:16]});
			expect_rd(wa(4'h4), {16'h0, ptr});
			if (m > 0) begin
				expect_rd(OFS_EADDR, (m >= 4) ? ptr : 32'h27FE);
			end
		end
		// Accumulator products, integer to A then fraction to B.
		setw(4'h0, 16'h9823);
		setw(4'h1, 16'h67DC);
		apb(1'b1, OFS_CORE_CTRL, 32'h1);
		exec(24'hB98701);
		expect_rd(OFS_ACCUMULATOR_A_LO, 32'hD5DC_D314);
		expect_rd(OFS_ACCUMULATOR_A_HI, 32'hFF);
		apb(1'b1, OFS_CORE_CTRL, 32'h3000);
		exec(24'hB98781);
		expect_rd(OFS_ACCUMULATOR_B_LO, 32'hABB9_A628);
		expect_rd(OFS_ACCUMULATOR_B_HI, 32'hFF);
		expect_rd(OFS_ACCUMULATOR_A_LO, 32'hD5DC_D314);
		// Literal products at both ends of the literal range.
		setw(4'h0, 16'hC000);
		exec(24'hB9017F);
		expect_rd(wa(4'h2), 32'h4000);
		expect_rd(wa(4'h3), 32'hFFF8);
		exec(24'hB90160);
		expect_rd(wa(4'h3), 32'h0);
		// Refused accesses and an undecodable opcode.
		apb(1'b0, 8'h24, 32'h0);
		check({39'h0, err}, 40'h1);
		apb(1'b1, 8'h42, 32'h5555);
		check({39'h0, err}, 40'h1);
		expect_rd(wa(4'h0), 32'hC000);
		exec(24'hFF0000);
		expect_rd(wa(4'h2), 32'h0);
		expect_rd(OFS_STATUS, 32'h1FFF_0001);
		apb(1'b1, OFS_STATUS, 32'h1);
		expect_rd(OFS_STATUS, 32'h1FFF_0000);
		test_done();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		repeat (20000) @(posedge clock_i);
		failures++;
		test_done();
	end
endmodule
